// ---- rtl/ipfe_defines.svh ----
// constants of the interrupt pin front end
`ifndef IPFE_DEFINES_SVH
`define IPFE_DEFINES_SVH
`define IPFE_NUM_REQ        5
`define IPFE_VEC_W          8
`define IPFE_VEC_NMI        8'h02
`define IPFE_VEC_REQ0       8'h0c
`define IPFE_VEC_REQ1       8'h0d
`define IPFE_VEC_REQ2       8'h0e
`define IPFE_VEC_REQ3       8'h0f
`define IPFE_VEC_REQ4       8'h11
`endif

// ---- rtl/ipfe_pkg.sv ----
// types of the interrupt pin front end
`default_nettype none
package ipfe_pkg;
	typedef enum logic [2:0] {
		IPFE_SRC_NONE,
		IPFE_SRC_NMI,
		IPFE_SRC_MASKABLE
	} ipfe_src_t;

	typedef struct packed {
		logic       valid;
		ipfe_src_t  src;
		logic [7:0] vector;
		logic [2:0] index;
	} ipfe_take_t;
endpackage
`default_nettype wire

// ---- rtl/ipfe_front_end.sv ----
// interrupt pin front end: request sync, triggering, cascade/slave pins, nmi
// Operation
// - sync every maskable request; edge or level mode
// - taken request zero to four uses own vector
// - cascade on request 0 makes pin 2 acknowledge
// - cascade on request 1 makes pin 3 acknowledge
// - slave mode makes pin 3 request output unless cascade on request 1 is set
// - nmi highest priority, unmaskable, fixed vector
// - nmi kept out of maskable priority resolution
// - no nmi in-service bit; nmi may nest
// - taking any interrupt clears interrupt enable flag
// - nmi rising edge latched, serviced at boundary
// - nmi held high through reset does nothing
`include "ipfe_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ipfe_front_end (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic [4:0]              ext_request_pin,
	input  wire logic                    nonmaskable_request,
	input  wire logic [4:0]              edge_mode,
	input  wire logic [4:0]              mask,
	input  wire logic [1:0]              cascade_mode,
	input  wire logic                    slave_mode,
	input  wire logic                    slave_request,
	input  wire logic                    boundary,
	input  wire logic                    ack_done,
	input  wire logic                    set_enable,
	output logic                         interrupt_enable_flag,
	output logic [4:0]                   pending,
	output ipfe_pkg::ipfe_take_t         take,
	output logic                         in_service,
	output logic                         cascade_ack_0,
	output logic                         cascade_ack_1,
	output logic                         slave_request_out,
	output logic [1:0]                   pin_oe
);
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic [4:0] sync_prev;
	logic [4:0] edge_latch;
	logic       nmi_s1;
	logic       nmi_s2;
	logic       nmi_prev;
	logic       nmi_latch;
	logic [4:0] ack_onehot;
	logic [2:0] serving;

	// pins 2 and 3 turned into outputs are not request inputs
	wire [4:0] input_use = {1'b1, ~(cascade_mode[1] | slave_mode), ~cascade_mode[0], 2'b11};
	wire [4:0] rising    = sync2 & ~sync_prev;
	wire [4:0] raw_req   = (edge_mode & edge_latch) | (~edge_mode & sync2);
	wire [4:0] req_vis   = raw_req & input_use;
	wire [4:0] eligible  = req_vis & ~mask;
	// nmi edge is found behind the same two flops as the request pins
	wire       nmi_rise  = nmi_s2 & ~nmi_prev;
	wire       nmi_pend  = nmi_latch | nmi_rise;
	// lowest index wins; nmi is decided apart from this chain
	wire [2:0] win_idx   = eligible[0] ? 3'd0 : eligible[1] ? 3'd1 : eligible[2] ? 3'd2 :
	                       eligible[3] ? 3'd3 : 3'd4;
	// nmi ignores mask and enable flag and beats every maskable source
	wire       take_nmi  = boundary & nmi_pend;
	// maskable takes wait while an nmi is pending
	wire       take_mask = boundary & ~nmi_pend & interrupt_enable_flag & (|eligible);
	// each input keeps its own vector entry
	wire [7:0] mask_vec  = (win_idx == 3'd0) ? `IPFE_VEC_REQ0 :
	                       (win_idx == 3'd1) ? `IPFE_VEC_REQ1 :
	                       (win_idx == 3'd2) ? `IPFE_VEC_REQ2 :
	                       (win_idx == 3'd3) ? `IPFE_VEC_REQ3 : `IPFE_VEC_REQ4;
	wire [4:0] take_bit  = take_mask ? (5'h01 << win_idx) : 5'h00;

	assign pending = req_vis;

	// synchroniser stages carry no reset: they only fill with pin levels
	always_ff @(posedge clk) begin
		sync1     <= ext_request_pin;
		sync2     <= sync1;
		nmi_s1    <= nonmaskable_request;
		nmi_s2    <= nmi_s1;
		if (rst) begin
			sync_prev  <= 5'h1f;
			edge_latch <= 5'h00;
			nmi_prev   <= 1'b1;
			nmi_latch  <= 1'b0;
		end else begin
			sync_prev  <= sync2;
			// new edge wins over a same-cycle take
			// level inputs keep no latch, else a stale edge shows up on a mode change
			edge_latch <= ((edge_latch & ~take_bit) | rising) & edge_mode;
			nmi_prev   <= nmi_s2;
			// latched until the next boundary; a fresh edge re-arms it
			nmi_latch  <= nmi_pend & ~take_nmi | (take_nmi & nmi_latch & nmi_rise);
		end
	end

	// reset primes the previous-value flops high so a held level is no edge

	// take record stands one cycle only; its users must catch it then
	always_ff @(posedge clk) begin
		if (rst) begin
			interrupt_enable_flag <= 1'b0;
			take                  <= '0;
			in_service            <= 1'b0;
			serving               <= 3'd0;
		end else begin
			take.valid <= take_nmi | take_mask;
			take.src   <= take_nmi ? ipfe_pkg::IPFE_SRC_NMI :
			              take_mask ? ipfe_pkg::IPFE_SRC_MASKABLE : ipfe_pkg::IPFE_SRC_NONE;
			take.vector <= take_nmi ? `IPFE_VEC_NMI : take_mask ? mask_vec : 8'h00;
			take.index  <= take_mask ? win_idx : 3'd0;
			if (take_nmi | take_mask) begin
				interrupt_enable_flag <= 1'b0;
			end else if (set_enable) begin
				interrupt_enable_flag <= 1'b1;
			end
			// only maskable takes enter service; nmi has no bit
			if (take_mask) begin
				in_service <= 1'b1;
				serving    <= win_idx;
			end else if (ack_done) begin
				in_service <= 1'b0;
			end
		end
	end

	assign ack_onehot = in_service ? (5'h01 << serving) : 5'h00;

	// pins are registered so a turned-around pin never glitches
	always_ff @(posedge clk) begin
		if (rst) begin
			cascade_ack_0     <= 1'b0;
			cascade_ack_1     <= 1'b0;
			slave_request_out <= 1'b0;
			pin_oe            <= 2'b00;
		end else begin
			cascade_ack_0     <= cascade_mode[0] & ack_onehot[0];
			cascade_ack_1     <= cascade_mode[1] & ack_onehot[1];
			slave_request_out <= slave_mode & ~cascade_mode[1] & slave_request;
			// cascade on pin 3 overrules slave mode when both are set
			pin_oe            <= {cascade_mode[1] | slave_mode, cascade_mode[0]};
		end
	end

	// checks below watch only what this block drives
	property nmi_vector_p;
		@(posedge clk) disable iff (rst)
		take_nmi |=> take.valid && take.vector == `IPFE_VEC_NMI && !interrupt_enable_flag;
	endproperty
	nmi_vector_a: assert property (nmi_vector_p) else $error("nmi take wrong");

	nmi_not_masked_a: assert property (@(posedge clk) disable iff (rst)
		boundary && nmi_pend |=> take.src == ipfe_pkg::IPFE_SRC_NMI)
		else $error("nmi blocked");

	take_clears_if_a: assert property (@(posedge clk) disable iff (rst)
		take_nmi || take_mask |=> !interrupt_enable_flag)
		else $error("enable flag not cleared");

	sequence nmi_edge_s;
		!nmi_s1 ##1 nmi_s1 && !rst;
	endsequence
	nmi_latch_edge_a: assert property (@(posedge clk) disable iff (rst)
		nmi_edge_s ##1 !boundary |=> nmi_latch)
		else $error("nmi edge lost");

	vector_own_a: assert property (@(posedge clk) disable iff (rst)
		take_mask && win_idx == 3'd2 |=> take.vector == `IPFE_VEC_REQ2)
		else $error("wrong vector for request 2");

	cascade_ack_a: assert property (@(posedge clk) disable iff (rst)
		cascade_ack_0 |-> $past(cascade_mode[0]) && $past(in_service) && $past(serving) == 3'd0)
		else $error("cascade ack without cause");

	cascade_ack1_a: assert property (@(posedge clk) disable iff (rst)
		cascade_ack_1 |-> $past(cascade_mode[1]))
		else $error("cascade ack 1 without mode");

	slave_out_a: assert property (@(posedge clk) disable iff (rst)
		slave_mode && !cascade_mode[1] && slave_request |=> slave_request_out)
		else $error("slave request not driven");

	// second stage follows the first one clock later
	level_sync_a: assert property (@(posedge clk) disable iff (rst)
		sync2 == $past(sync1))
		else $error("sync order broken");

	// nmi take leaves the maskable service state alone
	nmi_nest_a: assert property (@(posedge clk) disable iff (rst)
		take_nmi && !ack_done |=> in_service == $past(in_service))
		else $error("nmi touched service state");

	// a maskable winner is chosen by index alone
	low_index_wins_a: assert property (@(posedge clk) disable iff (rst)
		boundary && !nmi_pend && interrupt_enable_flag && eligible[0]
		|=> take.src == ipfe_pkg::IPFE_SRC_MASKABLE && take.index == 3'd0)
		else $error("maskable priority wrong");

	// first sample after reset sees no edge even with pins high
	reset_no_edge_a: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> !nmi_rise && rising == 5'h00)
		else $error("false edge after reset");

	// an edge in edge mode is held until taken
	edge_capture_a: assert property (@(posedge clk) disable iff (rst)
		(rising & edge_mode) != 5'h00 |=> edge_latch != 5'h00)
		else $error("edge not captured");

	sequence cascade0_take_s;
		take_mask && win_idx == 3'd0 && cascade_mode[0];
	endsequence
	sequence cascade0_ack_s;
		in_service ##1 cascade_ack_0;
	endsequence
	// take on request 0 in cascade mode raises the acknowledge two cycles on
	cascade_walk_a: assert property (@(posedge clk) disable iff (rst)
		cascade0_take_s ##1 cascade_mode[0] |-> cascade0_ack_s)
		else $error("cascade ack late");
endmodule
`default_nettype wire

// ---- dv/ipfe_periph.sv ----
// far-side peripherals that raise maskable requests
`timescale 1ns/1ps
`default_nettype none
module ipfe_periph #(
	parameter logic [7:0] TYPE_0 = 8'h40, // arbitrary types of the two cascaded peripherals
	parameter logic [7:0] TYPE_1 = 8'h41
) (
	input  wire logic                 clk,
	input  wire logic [4:0]           raise,
	input  wire ipfe_pkg::ipfe_take_t take,
	input  wire logic [1:0]           ack,
	output logic [4:0]                req,
	output logic [7:0]                cascade_type
);
	// the type stands on the bus while its acknowledge stands
	assign cascade_type = ack[0] ? TYPE_0 : ack[1] ? TYPE_1 : 8'h00;
	initial req = 5'h00;
	// line stays up until a take with its index; an nmi take carries index 0 and drops line 0 too
	always @(posedge clk) begin
		for (int i = 0; i < 5; i++) begin
			if (raise[i])
				req[i] <= 1'b1;
			else if (take.valid && take.index == 3'(i))
				req[i] <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- dv/ipfe_front_end_tb.sv ----
// self-checking bench of the interrupt pin front end
`include "ipfe_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ipfe_front_end_tb;
	logic                 clk = 1'b0, rst = 1'b1, nmi = 1'b1, sreq = 1'b0;
	logic                 se = 1'b0, ad = 1'b0, slv = 1'b0, ief, ins, ca0, ca1, sro;
	logic [1:0]           csc = 2'h0, oe;
	logic [4:0]           em = 5'h00, raise = 5'h00, req, pnd, msk = 5'h00;
	logic                 bnd = 1'b1;
	logic [7:0]           ctype;
	ipfe_pkg::ipfe_take_t take, got;
	int                   num_errors = 0, compares = 0, takes = 0, t0 = 0;
	logic [11:0]          rows [5] = '{{3'h0, 1'h0, `IPFE_VEC_REQ0},
		{3'h1, 1'h1, `IPFE_VEC_REQ1}, {3'h2, 1'h0, `IPFE_VEC_REQ2},
		{3'h3, 1'h1, `IPFE_VEC_REQ3}, {3'h4, 1'h0, `IPFE_VEC_REQ4}};
	always #2 clk = ~clk;
	always @(posedge clk) if (take.valid === 1'b1) takes <= takes + 1;
	ipfe_periph u_ipfe_periph (.clk(clk), .raise(raise), .take(take), .ack({ca1, ca0}),
		.req(req), .cascade_type(ctype));
	ipfe_front_end u_ipfe_front_end (.clk(clk), .rst(rst), .ext_request_pin(req),
		.nonmaskable_request(nmi), .edge_mode(em), .mask(msk), .cascade_mode(csc),
		.slave_mode(slv), .slave_request(sreq), .boundary(bnd), .ack_done(ad),
		.set_enable(se), .interrupt_enable_flag(ief), .pending(pnd), .take(take),
		.in_service(ins), .cascade_ack_0(ca0), .cascade_ack_1(ca1),
		.slave_request_out(sro), .pin_oe(oe));
	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task automatic give_verdict;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// sampled on the falling edge so no race with the design's own updates
	task automatic wait_take;
		int n;
		n = 0;
		@(negedge clk);
		while (take.valid !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		got = take;
		if (n == 30) begin
			chk(1'b0, "no take");
			give_verdict();
		end
	endtask
	task automatic go(input logic [4:0] r);
		@(posedge clk);
		se <= 1'b1;
		ad <= 1'b1;
		raise <= r;
		@(posedge clk);
		se <= 1'b0;
		ad <= 1'b0;
		raise <= 5'h00;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		chk(takes == 0 && ief === 1'b0 && ins === 1'b0, "nmi level through reset taken");
		se <= 1'b1;
		msk <= 5'h1f;
		nmi <= 1'b0;
		@(posedge clk);
		se <= 1'b0;
		nmi <= 1'b1;
		wait_take();
		chk(got.src === ipfe_pkg::IPFE_SRC_NMI, "nmi source");
		chk(got.vector === `IPFE_VEC_NMI && ief === 1'b0, "nmi vector");
		$display("test nmi done");
		@(posedge clk);
		msk <= 5'h00;
		foreach (rows[i]) begin
			@(posedge clk);
			em <= rows[i][8] ? 5'h1f : 5'h00;
			go(5'h01 << rows[i][11:9]);
			wait_take();
			chk(got.index === rows[i][11:9] && got.vector === rows[i][7:0], "vector");
			chk(ief === 1'b0 && ins === 1'b1, "enable flag kept");
		end
		$display("test rows done");
		@(posedge clk);
		csc <= 2'h1;
		go(5'h01);
		wait_take();
		repeat (2) @(negedge clk);
		chk(ca0 === 1'b1 && oe[0] === 1'b1, "cascade ack");
		chk(ctype === 8'h40, "cascade type 0");
		@(posedge clk);
		ad <= 1'b1;
		@(posedge clk);
		ad <= 1'b0;
		repeat (2) @(negedge clk);
		chk(ca0 === 1'b0 && ins === 1'b0 && ctype === 8'h00, "cascade release");
		@(posedge clk);
		csc <= 2'h3;
		go(5'h02);
		wait_take();
		repeat (2) @(negedge clk);
		chk(ca1 === 1'b1 && oe === 2'b11 && got.vector === `IPFE_VEC_REQ1, "cascade ack 1");
		chk(ctype === 8'h41, "cascade type 1");
		$display("test cascade done");
		@(posedge clk);
		ad <= 1'b1;
		csc <= 2'h0;
		msk <= 5'h10;
		@(posedge clk);
		ad <= 1'b0;
		t0 = takes;
		go(5'h10);
		repeat (6) @(negedge clk);
		chk(takes == t0 && pnd === 5'h10, "masked request taken");
		@(posedge clk);
		msk <= 5'h00;
		wait_take();
		chk(got.vector === `IPFE_VEC_REQ4 && got.index === 3'h4, "unmasked request 4");
		$display("test mask done");
		@(posedge clk);
		bnd <= 1'b0;
		nmi <= 1'b0;
		@(posedge clk);
		nmi <= 1'b1;
		t0 = takes;
		repeat (8) @(posedge clk);
		chk(takes == t0, "nmi taken off boundary");
		bnd <= 1'b1;
		wait_take();
		chk(got.src === ipfe_pkg::IPFE_SRC_NMI && ins === 1'b1, "nmi over service");
		$display("test boundary done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t0 = takes;
		repeat (6) @(negedge clk);
		chk(takes == t0 && ief === 1'b0 && ins === 1'b0 && oe === 2'b00, "second reset");
		$display("test second reset done");
		@(posedge clk);
		slv <= 1'b1;
		sreq <= 1'b1;
		repeat (3) @(negedge clk);
		chk(sro === 1'b1 && oe[1] === 1'b1, "slave request");
		$display("test slave done");
		give_verdict();
	end
endmodule
`default_nettype wire
